// File: insn_decode_map.vh
// Constants for the instruction format decoder and cycle sequencer
`ifndef INSN_DECODE_MAP_VH
`define INSN_DECODE_MAP_VH

`define IW_WIDTH        14
`define CAT_MSB         13
`define CAT_LSB         12
`define CAT_BYTE        2'h0
`define CAT_BIT         2'h1
`define CAT_JUMP        2'h2
`define CAT_LIT         2'h3
`define BYTE_OP_MSB     11
`define BYTE_OP_LSB     8
`define DEST_BIT        7
`define FILE_MSB        6
`define FILE_LSB        0
`define BIT_OP_MSB      11
`define BIT_OP_LSB      10
`define BITSEL_MSB      9
`define BITSEL_LSB      7
`define LIT8_MSB        7
`define LIT11_MSB       10
`define FILE_MAX        7'h7f
`define OSC_PER_CYCLE   4
`define PHASE_LAST      2'h3

`define BOP_MOVWF_CLR   4'h0
`define BOP_CLR         4'h1
`define BOP_SUB         4'h2
`define BOP_DEC         4'h3
`define BOP_IOR         4'h4
`define BOP_AND         4'h5
`define BOP_XOR         4'h6
`define BOP_ADD         4'h7
`define BOP_MOV         4'h8
`define BOP_COM         4'h9
`define BOP_INC         4'ha
`define BOP_DECSZ       4'hb
`define BOP_RRC         4'hc
`define BOP_RLC         4'hd
`define BOP_SWAP        4'he
`define BOP_INCSZ       4'hf

`define BIT_CLR         2'h0
`define BIT_SET         2'h1
`define BIT_TSTC        2'h2
`define BIT_TSTS        2'h3

`define CTL_RETURN      8'h08
`define CTL_RETFIE      8'h09
`define CTL_SLEEP       8'h63
`define CTL_CLRWDT      8'h64

`define ALU_PASS        4'h0
`define ALU_ADD         4'h1
`define ALU_SUB         4'h2
`define ALU_AND         4'h3
`define ALU_IOR         4'h4
`define ALU_XOR         4'h5
`define ALU_COM         4'h6
`define ALU_INC         4'h7
`define ALU_DEC         4'h8
`define ALU_RRC         4'h9
`define ALU_RLC         4'ha
`define ALU_SWAP        4'hb
`define ALU_BCLR        4'hc
`define ALU_BSET        4'hd
`define ALU_ZERO        4'he
`define ALU_LIT         4'hf

`endif

// File: insn_fields.v
// Combinational split of one program word into its fields
`timescale 1ns/10ps
`default_nettype none
`include "insn_decode_map.vh"

module insn_fields (
  input  wire [13:0] word_i,
  output reg  [1:0]  cat_o,
  output reg  [6:0]  file_o,
  output reg         dest_file_o,
  output reg  [2:0]  bit_sel_o,
  output reg  [7:0]  lit8_o,
  output reg  [10:0] lit11_o,
  output reg         uses_file_o
);
  always @* begin
    cat_o       = word_i[`CAT_MSB:`CAT_LSB];
    file_o      = word_i[`FILE_MSB:`FILE_LSB];
    dest_file_o = word_i[`DEST_BIT];
    bit_sel_o   = word_i[`BITSEL_MSB:`BITSEL_LSB];
    lit8_o      = word_i[`LIT8_MSB:0];
    lit11_o     = word_i[`LIT11_MSB:0];
    uses_file_o = 1'b0;
    case (cat_o)
      `CAT_BYTE: begin
        uses_file_o = (word_i[`BYTE_OP_MSB:`BYTE_OP_LSB] != 4'h0) ||
                      word_i[`DEST_BIT];
      end
      `CAT_BIT:  uses_file_o = 1'b1;
      default:   uses_file_o = 1'b0;
    endcase
  end
endmodule // insn_fields

`default_nettype wire

// File: insn_format_decode.v
// Instruction format decode, cycle timing and file read-modify-store
`timescale 1ns/10ps
`default_nettype none
`include "insn_decode_map.vh"

module insn_format_decode #(
  parameter PC_WIDTH = 13,
  parameter PORT_MASK = 128'h0
) (
  input  wire                ref_clk_i,
  input  wire                rstn_i,
  input  wire [13:0]         insn_i,
  input  wire [7:0]          file_rdata_i,
  input  wire [7:0]          pin_rdata_i,
  input  wire [PC_WIDTH-1:0] stack_top_i,
  output reg  [PC_WIDTH-1:0] program_counter_o,
  output reg                 fetch_o,
  output reg  [1:0]          phase_o,
  output reg  [6:0]          file_addr_o,
  output reg                 file_rd_o,
  output reg                 file_wr_o,
  output reg  [7:0]          file_wdata_o,
  output reg  [7:0]          acc_o,
  output reg                 carry_o,
  output reg                 zero_o,
  output reg                 nop_cycle_o,
  output reg                 push_o,
  output reg                 pop_o,
  output reg                 sleep_o,
  output reg                 clrwdt_o
);
  wire [1:0]  cat;
  wire [6:0]  fidx;
  wire        dest_file;
  wire [2:0]  bsel;
  wire [7:0]  lit8;
  wire [10:0] lit11;
  wire        uses_file;

  reg  [1:0]  phase_r;
  reg  [13:0] ir_r;
  reg         flush_r;
  reg  [7:0]  operand_r;
  reg  [PC_WIDTH-1:0] pc_r;
  reg  [7:0]  acc_r;
  reg         c_r;
  reg         z_r;

  reg  [3:0]  alu_op;
  reg  [7:0]  alu_b;
  reg  [8:0]  alu_res;
  reg         wr_file;
  reg         wr_acc;
  reg         upd_z;
  reg         upd_c;
  reg         skip;
  reg         jump;
  reg  [PC_WIDTH-1:0] jump_to;
  reg         do_push;
  reg         do_pop;
  reg         do_sleep;
  reg         do_clrwdt;
  reg  [7:0]  mask;

  insn_fields u_fields (
    .word_i      (ir_r),
    .cat_o       (cat),
    .file_o      (fidx),
    .dest_file_o (dest_file),
    .bit_sel_o   (bsel),
    .lit8_o      (lit8),
    .lit11_o     (lit11),
    .uses_file_o (uses_file)
  );

  always @* begin
    alu_op    = `ALU_PASS;
    alu_b     = operand_r;
    wr_file   = 1'b0;
    wr_acc    = 1'b0;
    upd_z     = 1'b0;
    upd_c     = 1'b0;
    skip      = 1'b0;
    jump      = 1'b0;
    jump_to   = {PC_WIDTH{1'b0}};
    do_push   = 1'b0;
    do_pop    = 1'b0;
    do_sleep  = 1'b0;
    do_clrwdt = 1'b0;
    mask      = 8'h01 << bsel;
    case (cat)
      `CAT_BYTE: begin
        wr_file = dest_file;
        wr_acc  = ~dest_file;
        upd_z   = 1'b1;
        case (ir_r[`BYTE_OP_MSB:`BYTE_OP_LSB])
          `BOP_MOVWF_CLR: begin
            wr_acc  = 1'b0;
            upd_z   = 1'b0;
            alu_op  = `ALU_LIT;
            alu_b   = acc_r;
            if (!dest_file) begin
              case (ir_r[7:0])
                `CTL_RETURN, `CTL_RETFIE: begin
                  do_pop = 1'b1;
                  jump   = 1'b1;
                  jump_to = stack_top_i;
                end
                `CTL_SLEEP:  do_sleep  = 1'b1;
                `CTL_CLRWDT: do_clrwdt = 1'b1;
                default: ;
              endcase
            end
          end
          `BOP_CLR:   begin alu_op = `ALU_ZERO; wr_acc = ~dest_file; end
          `BOP_SUB:   begin alu_op = `ALU_SUB; upd_c = 1'b1; end
          `BOP_DEC:   alu_op = `ALU_DEC;
          `BOP_IOR:   alu_op = `ALU_IOR;
          `BOP_AND:   alu_op = `ALU_AND;
          `BOP_XOR:   alu_op = `ALU_XOR;
          `BOP_ADD:   begin alu_op = `ALU_ADD; upd_c = 1'b1; end
          `BOP_MOV:   alu_op = `ALU_PASS;
          `BOP_COM:   alu_op = `ALU_COM;
          `BOP_INC:   alu_op = `ALU_INC;
          `BOP_DECSZ: begin alu_op = `ALU_DEC; upd_z = 1'b0; end
          `BOP_RRC:   begin alu_op = `ALU_RRC; upd_c = 1'b1; upd_z = 1'b0; end
          `BOP_RLC:   begin alu_op = `ALU_RLC; upd_c = 1'b1; upd_z = 1'b0; end
          `BOP_SWAP:  begin alu_op = `ALU_SWAP; upd_z = 1'b0; end
          `BOP_INCSZ: begin alu_op = `ALU_INC; upd_z = 1'b0; end
          default:    alu_op = `ALU_PASS;
        endcase
      end
      `CAT_BIT: begin
        alu_b = mask;
        case (ir_r[`BIT_OP_MSB:`BIT_OP_LSB])
          `BIT_CLR:  begin alu_op = `ALU_BCLR; wr_file = 1'b1; end
          `BIT_SET:  begin alu_op = `ALU_BSET; wr_file = 1'b1; end
          `BIT_TSTC: skip = ~|(operand_r & mask);
          `BIT_TSTS: skip = |(operand_r & mask);
          default:   skip = 1'b0;
        endcase
      end
      `CAT_JUMP: begin
        jump    = 1'b1;
        jump_to = {{(PC_WIDTH-11){1'b0}}, lit11};
        do_push = ~ir_r[11];
      end
      default: begin
        alu_b  = lit8;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
        casez (ir_r[11:8])
          4'b1000: alu_op = `ALU_IOR;
          4'b1001: alu_op = `ALU_AND;
          4'b1010: alu_op = `ALU_XOR;
          4'b110?: begin alu_op = `ALU_SUB; upd_c = 1'b1; end
          4'b111?: begin alu_op = `ALU_ADD; upd_c = 1'b1; end
          4'b00??: begin alu_op = `ALU_LIT; upd_z = 1'b0; end
          4'b01??: begin
            alu_op  = `ALU_LIT;
            upd_z   = 1'b0;
            do_pop  = 1'b1;
            jump    = 1'b1;
            jump_to = stack_top_i;
          end
          default: alu_op = `ALU_LIT;
        endcase
      end
    endcase
    case (alu_op)
      `ALU_ADD:  alu_res = {1'b0, alu_b} + {1'b0, acc_r};
      `ALU_SUB:  alu_res = {1'b0, alu_b} + {1'b0, ~acc_r} + 9'h001;
      `ALU_AND:  alu_res = {1'b0, alu_b & acc_r};
      `ALU_IOR:  alu_res = {1'b0, alu_b | acc_r};
      `ALU_XOR:  alu_res = {1'b0, alu_b ^ acc_r};
      `ALU_COM:  alu_res = {1'b0, ~alu_b};
      `ALU_INC:  alu_res = {1'b0, alu_b + 8'h01};
      `ALU_DEC:  alu_res = {1'b0, alu_b - 8'h01};
      `ALU_RRC:  alu_res = {alu_b[0], c_r, alu_b[7:1]};
      `ALU_RLC:  alu_res = {alu_b[7], alu_b[6:0], c_r};
      `ALU_SWAP: alu_res = {1'b0, alu_b[3:0], alu_b[7:4]};
      `ALU_BCLR: alu_res = {1'b0, operand_r & ~alu_b};
      `ALU_BSET: alu_res = {1'b0, operand_r | alu_b};
      `ALU_ZERO: alu_res = 9'h000;
      `ALU_LIT:  alu_res = {1'b0, alu_b};
      default:   alu_res = {1'b0, alu_b};
    endcase
    if (cat == `CAT_BYTE &&
        (ir_r[11:8] == `BOP_DECSZ || ir_r[11:8] == `BOP_INCSZ))
      skip = (alu_res[7:0] == 8'h00);
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_r           <= 2'h0;
      ir_r              <= 14'h0000;
      flush_r           <= 1'b1;
      operand_r         <= 8'h00;
      pc_r              <= {PC_WIDTH{1'b0}};
      acc_r             <= 8'h00;
      c_r               <= 1'b0;
      z_r               <= 1'b0;
      program_counter_o <= {PC_WIDTH{1'b0}};
      fetch_o           <= 1'b0;
      phase_o           <= 2'h0;
      file_addr_o       <= 7'h00;
      file_rd_o         <= 1'b0;
      file_wr_o         <= 1'b0;
      file_wdata_o      <= 8'h00;
      acc_o             <= 8'h00;
      carry_o           <= 1'b0;
      zero_o            <= 1'b0;
      nop_cycle_o       <= 1'b1;
      push_o            <= 1'b0;
      pop_o             <= 1'b0;
      sleep_o           <= 1'b0;
      clrwdt_o          <= 1'b0;
    end else begin
      phase_r     <= phase_r + 2'h1;
      phase_o     <= phase_r + 2'h1;
      fetch_o     <= 1'b0;
      file_rd_o   <= 1'b0;
      file_wr_o   <= 1'b0;
      push_o      <= 1'b0;
      pop_o       <= 1'b0;
      sleep_o     <= 1'b0;
      clrwdt_o    <= 1'b0;
      case (phase_r)
        2'h0: begin
          if (!flush_r && uses_file) begin
            file_addr_o <= fidx & `FILE_MAX;
            file_rd_o   <= 1'b1;
          end
        end
        2'h1: begin
          operand_r <= PORT_MASK[fidx] ? pin_rdata_i : file_rdata_i;
        end
        2'h2: ;
        default: begin
          if (!flush_r) begin
            if (wr_file) begin
              file_wr_o    <= 1'b1;
              file_wdata_o <= alu_res[7:0];
            end
            if (wr_acc)
              acc_r <= alu_res[7:0];
            if (wr_acc)
              acc_o <= alu_res[7:0];
            if (upd_c) begin
              c_r     <= alu_res[8];
              carry_o <= alu_res[8];
            end
            if (upd_z) begin
              z_r    <= (alu_res[7:0] == 8'h00);
              zero_o <= (alu_res[7:0] == 8'h00);
            end
            push_o   <= do_push;
            pop_o    <= do_pop;
            sleep_o  <= do_sleep;
            clrwdt_o <= do_clrwdt;
          end
          flush_r     <= !flush_r && (skip || jump);
          nop_cycle_o <= !flush_r && (skip || jump);
          ir_r        <= insn_i;
          fetch_o     <= 1'b1;
          if (!flush_r && jump) begin
            pc_r              <= jump_to;
            program_counter_o <= jump_to;
          end else begin
            pc_r              <= pc_r + {{(PC_WIDTH-1){1'b0}}, 1'b1};
            program_counter_o <= pc_r + {{(PC_WIDTH-1){1'b0}}, 1'b1};
          end
        end
      endcase
    end
  end
endmodule // insn_format_decode

`default_nettype wire

// File: insn_format_decode_chk.sv
// Assertion checker for the instruction format decoder
`timescale 1ns/10ps
`default_nettype none
module insn_format_decode_chk (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [13:0] insn_i,
  input wire logic        fetch_o,
  input wire logic [1:0]  phase_o,
  input wire logic [6:0]  file_addr_o,
  input wire logic        file_rd_o,
  input wire logic        file_wr_o,
  input wire logic        nop_cycle_o
);
  logic [6:0] insn_file;
  logic       wr_ok;
  assign insn_file = insn_i[6:0];
  assign wr_ok = (insn_i[13:12] == 2'h1) || insn_i[7];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_phase_step: assert property ($past(rstn_i) |->
    phase_o == $past(phase_o) + 2'h1) else $error("phase skipped");
  a_fetch_phase: assert property (fetch_o |-> phase_o == 2'h0)
    else $error("fetch outside phase zero");
  a_fetch_space: assert property (fetch_o |=> !fetch_o [*3] ##1 fetch_o)
    else $error("fetch spacing not four clocks");
  a_rd_phase: assert property (file_rd_o |-> phase_o == 2'h1
    && $past(fetch_o)) else $error("file read off phase one");
  a_rd_addr: assert property (file_rd_o |->
    file_addr_o == $past(insn_file, 2)) else $error("wrong file index");
  a_wr_after_rd: assert property (file_wr_o |->
    $past(file_rd_o, 3) && fetch_o) else $error("write without read");
  a_wr_dest: assert property (file_wr_o |-> $past(wr_ok, 5))
    else $error("file write with accumulator destination");
  a_nop_span: assert property ($rose(nop_cycle_o) |-> nop_cycle_o [*4])
    else $error("flushed cycle too short");
  a_rd_not_nop: assert property (file_rd_o |-> !nop_cycle_o)
    else $error("file read in flushed cycle");
  c_write: cover property (file_wr_o);
  c_flush: cover property ($rose(nop_cycle_o));
  c_top_file: cover property (file_rd_o && file_addr_o == 7'h7f);
endmodule // insn_format_decode_chk
bind insn_format_decode insn_format_decode_chk chk_inst (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .insn_i(insn_i),
  .fetch_o(fetch_o), .phase_o(phase_o), .file_addr_o(file_addr_o),
  .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .nop_cycle_o(nop_cycle_o));
`default_nettype wire

// File: prog_and_file_model.sv
// Program memory, register file and return stack model
`timescale 1ns/10ps
`default_nettype none
module prog_and_file_model #(
  parameter PC_WIDTH = 13
) (
  input  wire logic                ref_clk_i,
  input  wire logic [PC_WIDTH-1:0] program_counter_i,
  input  wire logic [6:0]          file_addr_i,
  input  wire logic                file_rd_i,
  input  wire logic                file_wr_i,
  input  wire logic [7:0]          file_wdata_i,
  input  wire logic                push_i,
  output wire logic [13:0]         insn_o,
  output wire logic [7:0]          rdata_o,
  output var  logic [PC_WIDTH-1:0] stack_top_o
);
  logic [13:0]         rom [0:(1<<PC_WIDTH)-1];
  logic [7:0]          regs [0:127];
  int                  rd_cnt [0:127];
  logic [7:0]          last_r;
  logic [PC_WIDTH-1:0] prev_pc_r;
  initial begin
    last_r = 8'h00;
    prev_pc_r = '0;
    stack_top_o = '0;
  end
  assign insn_o = rom[program_counter_i];
  // Data stands while the read strobe is high; idle bus shows junk
  assign rdata_o = file_rd_i ? regs[file_addr_i] : ~last_r;
  always @(posedge ref_clk_i) begin
    if (file_rd_i) begin
      last_r <= regs[file_addr_i];
      rd_cnt[file_addr_i] <= rd_cnt[file_addr_i] + 1;
    end
    if (file_wr_i) regs[file_addr_i] <= file_wdata_i;
    // Push comes after the jump; return address is the old counter
    prev_pc_r <= program_counter_i;
    if (push_i) stack_top_o <= prev_pc_r;
  end
endmodule // prog_and_file_model
`default_nettype wire

// File: insn_format_decode_test.sv
// Self-checking testbench for the instruction format decoder
`timescale 1ns/10ps
`default_nettype none
module insn_format_decode_test;
  logic        ref_clk_i;
  logic        rstn_i;
  logic [7:0]  pin_rdata_i;
  wire  [13:0] insn;
  wire  [7:0]  file_rdata, file_wdata, acc;
  wire  [12:0] stack_top, pc;
  wire  [1:0]  phase;
  wire  [6:0]  file_addr;
  wire         fetch, file_rd, file_wr, nop_cycle, push, pop, clrwdt;
  wire         carry, zero, sleep;
  int          n_fail, n_checks, n_clrwdt, n_pop;

  insn_format_decode #(.PC_WIDTH(13), .PORT_MASK(128'h40))
    insn_format_decode_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .insn_i(insn),
    .file_rdata_i(file_rdata), .pin_rdata_i(pin_rdata_i),
    .stack_top_i(stack_top), .program_counter_o(pc), .fetch_o(fetch),
    .phase_o(phase), .file_addr_o(file_addr), .file_rd_o(file_rd),
    .file_wr_o(file_wr), .file_wdata_o(file_wdata), .acc_o(acc),
    .carry_o(carry), .zero_o(zero), .nop_cycle_o(nop_cycle),
    .push_o(push), .pop_o(pop), .sleep_o(sleep), .clrwdt_o(clrwdt));

  prog_and_file_model #(.PC_WIDTH(13)) prog_and_file_model_inst (
    .ref_clk_i(ref_clk_i), .program_counter_i(pc),
    .file_addr_i(file_addr), .file_rd_i(file_rd), .file_wr_i(file_wr),
    .file_wdata_i(file_wdata), .push_i(push), .insn_o(insn),
    .rdata_o(file_rdata), .stack_top_o(stack_top));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (clrwdt === 1'b1) n_clrwdt++;
    if (pop === 1'b1) n_pop++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Reset for 20 cycles and clear both memories
  task automatic restart;
    @(posedge ref_clk_i) #1 rstn_i = 1'b0;
    for (int i = 0; i < 8192; i++) prog_and_file_model_inst.rom[i] = 14'h0;
    for (int i = 0; i < 128; i++) begin
      prog_and_file_model_inst.regs[i] = 8'h00;
      prog_and_file_model_inst.rd_cnt[i] = 0;
    end
    n_clrwdt = 0;
    n_pop = 0;
    repeat (20) @(posedge ref_clk_i);
    #1;
  endtask

  // Release reset, await first fetch, run n instruction cycles
  task automatic go(input int n);
    int k;
    rstn_i = 1'b1;
    k = 0;
    while (fetch !== 1'b1 && k < 8) begin
      @(posedge ref_clk_i);
      #1 k++;
    end
    if (k < 8) repeat (4 * n) @(posedge ref_clk_i);
    else begin
      n_fail++;
      tally_and_finish();
    end
    #1;
  endtask

  task automatic test_literal;
    restart();
    prog_and_file_model_inst.rom[0] = 14'h0064;
    prog_and_file_model_inst.rom[1] = 14'h335a;
    prog_and_file_model_inst.rom[2] = 14'h380f;
    prog_and_file_model_inst.rom[3] = 14'h3ea1;
    prog_and_file_model_inst.rom[4] = 14'h0063;
    go(3);
    check(acc, 8'h5f);
    check(n_clrwdt, 1);
    repeat (8) @(posedge ref_clk_i);
    #1;
    check(acc, 8'h00);
    check(carry, 1'b1);
    check(zero, 1'b1);
    check(sleep, 1'b1);
    $display("literal test done");
  endtask

  task automatic test_jump;
    restart();
    prog_and_file_model_inst.rom[0] = 14'h2123;
    prog_and_file_model_inst.rom[1] = 14'h3011;
    prog_and_file_model_inst.rom[13'h123] = 14'h3866;
    prog_and_file_model_inst.rom[13'h124] = 14'h0008;
    go(3);
    check(acc, 8'h66);
    repeat (12) @(posedge ref_clk_i);
    #1;
    check(n_pop, 1);
    check(acc, 8'h11);
    check(pc, 13'h003);
    $display("jump test done");
  endtask

  task automatic test_byte;
    restart();
    prog_and_file_model_inst.regs[7'h20] = 8'h0f;
    prog_and_file_model_inst.regs[7'h7f] = 8'haa;
    prog_and_file_model_inst.rom[0] = 14'h3001;
    prog_and_file_model_inst.rom[1] = 14'h0720;
    prog_and_file_model_inst.rom[2] = 14'h07a0;
    prog_and_file_model_inst.rom[3] = 14'h01ff;
    go(6);
    check(acc, 8'h10);
    check(prog_and_file_model_inst.regs[7'h20], 8'h1f);
    check(prog_and_file_model_inst.regs[7'h7f], 8'h00);
    check(prog_and_file_model_inst.rd_cnt[7'h7f], 1);
    check(prog_and_file_model_inst.rd_cnt[7'h20], 2);
    check(zero, 1'b1);
    $display("byte test done");
  endtask

  task automatic test_bits;
    restart();
    prog_and_file_model_inst.regs[7'h30] = 8'h01;
    prog_and_file_model_inst.rom[0] = 14'h17b0;
    prog_and_file_model_inst.rom[1] = 14'h1030;
    prog_and_file_model_inst.rom[2] = 14'h1830;
    prog_and_file_model_inst.rom[3] = 14'h3811;
    prog_and_file_model_inst.rom[4] = 14'h1fb0;
    prog_and_file_model_inst.rom[5] = 14'h3844;
    prog_and_file_model_inst.rom[6] = 14'h3822;
    go(10);
    check(prog_and_file_model_inst.regs[7'h30], 8'h80);
    check(acc, 8'h22);
    $display("bit test done");
  endtask

  task automatic test_port;
    restart();
    pin_rdata_i = 8'h3c;
    prog_and_file_model_inst.regs[7'h06] = 8'hff;
    prog_and_file_model_inst.rom[0] = 14'h0886;
    prog_and_file_model_inst.rom[1] = 14'h0806;
    go(4);
    check(prog_and_file_model_inst.regs[7'h06], 8'h3c);
    check(acc, 8'h3c);
    $display("port test done");
  endtask

  initial begin
    rstn_i = 1'b0;
    pin_rdata_i = 8'h00;
    n_fail = 0;
    n_checks = 0;
    test_literal();
    test_jump();
    test_byte();
    test_bits();
    test_port();
    tally_and_finish();
  end
endmodule // insn_format_decode_test
`default_nettype wire
